/* hw/lct_pkg.sv */
package lct_pkg;

  // ****************************************
  // Widths and timing
  // ****************************************
  localparam int NCH           = 8;
  localparam int DLY_W         = 16;
  localparam int CLK_PERIOD_NS = 4;
  localparam int PER_FAST_NS   = 100;
  localparam int PER_1US_NS    = 1000;
  localparam int PER_10US_NS   = 10000;
  localparam logic [11:0] PER_FAST_CYC = 12'(PER_FAST_NS / CLK_PERIOD_NS);
  localparam logic [11:0] PER_1US_CYC  = 12'(PER_1US_NS / CLK_PERIOD_NS);
  localparam logic [11:0] PER_10US_CYC = 12'(PER_10US_NS / CLK_PERIOD_NS);

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_TRIG    = 8'h08;
  localparam logic [7:0] OFS_DELAY   = 8'h0C;
  localparam logic [7:0] OFS_POL     = 8'h10;
  localparam logic [7:0] OFS_INMODE  = 8'h14;
  localparam logic [7:0] OFS_SEQ_MAP = 8'h18;
  localparam logic [7:0] OFS_SEQ_EN  = 8'h1C;
  localparam logic [7:0] OFS_IST     = 8'h20;
  localparam logic [7:0] OFS_ICLR    = 8'h24;
  localparam logic [7:0] OFS_IEN     = 8'h28;

  // ****************************************
  // Field positions and codes
  // ****************************************
  localparam int CTRL_ARM  = 0;
  localparam int CTRL_DIG  = 1;
  localparam int CTRL_SYNC = 2;
  localparam int CTRL_EDGE = 3;
  localparam int CTRL_PER  = 5;
  localparam int CTRL_EVT  = 7;
  localparam int STAT_CNT  = 2;
  localparam int IRQ_TRIG  = 0;
  localparam int IRQ_DONE  = 1;
  localparam logic [1:0] PER_SEL_FAST = 2'h0;
  localparam logic [1:0] PER_SEL_1US  = 2'h1;
  localparam logic [1:0] PER_SEL_10US = 2'h2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]  RST_CTRL    = 8'h0A;
  localparam logic [7:0]  RST_TRIG    = 8'h00;
  localparam logic [15:0] RST_DELAY   = 16'h0000;
  localparam logic [7:0]  RST_POL     = 8'h00;
  localparam logic [7:0]  RST_INMODE  = 8'h00;
  localparam logic [23:0] RST_SEQ_MAP = 24'hFAC688;
  localparam logic [7:0]  RST_SEQ_EN  = 8'hFF;
  localparam logic [1:0]  RST_IEN     = 2'h0;

  typedef enum logic [1:0] {
    LCT_IDLE  = 2'b00,
    LCT_ARMED = 2'b01,
    LCT_POST  = 2'b11,
    LCT_DONE  = 2'b10
  } lct_state_t;

endpackage

/* hw/lct_chan.sv */
module lct_chan (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Channel pin
  input  wire logic pin,
  // Control
  input  wire logic tick,
  input  wire logic latch_mode,
  input  wire logic negative,
  // Captured value
  output logic      value
);

  typedef struct packed {
    logic s0;
    logic s1;
    logic prev_raw;
    logic glitch;
    logic val;
  } lct_chan_st_t;

  lct_chan_st_t r;
  lct_chan_st_t next_r;
  logic         raw;

  always_comb
  begin
    next_r = r;
    raw = r.s1;
    next_r.s0 = pin;
    next_r.s1 = r.s0;
    next_r.glitch = r.glitch | (r.s1 != r.prev_raw);
    if (tick)
    begin
      if (latch_mode && next_r.glitch)
        raw = ~r.prev_raw;
      next_r.prev_raw = raw;
      next_r.glitch = 1'b0;
      next_r.val = raw ^ negative;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      r <= '0;
    else
      r <= next_r;
  end

  assign value = r.val;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  pol_sample_a: assert property (
    tick && !latch_mode |=> r.val == ($past(r.s1) ^ $past(negative)))
    else $error("sampled value not polarity corrected");
  latch_glitch_a: assert property (
    tick && latch_mode && (r.glitch || r.s1 != r.prev_raw)
      |=> r.val == (~$past(r.prev_raw) ^ $past(negative)))
    else $error("latch mode lost a glitch");
  glitch_cov: cover property (tick && latch_mode && r.glitch && r.s1 == r.prev_raw);

endmodule

/* hw/lct_top.sv */
module lct_top (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [7:0]  bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_we,
  input  wire logic        bus_re,
  output logic      [31:0] bus_rdata,
  // Target pins
  input  wire logic [7:0]  ch_pin,
  input  wire logic        ext_clk_pin,
  // Recording stream and events
  output logic             rec_valid,
  output logic      [7:0]  rec_data,
  output logic             trig_pulse,
  output logic             rec_done,
  output logic             irq
);

  typedef struct packed {
    logic                  ext_s0;
    logic                  ext_s1;
    logic                  ext_prev;
    logic                  dig;
    logic                  sync;
    logic [1:0]            edge_sel;
    logic [1:0]            per_sel;
    logic                  evt;
    logic [7:0]            trig_word;
    logic [15:0]           delay;
    logic [7:0]            pol;
    logic [7:0]            inmode;
    logic [23:0]           seq_map;
    logic [7:0]            seq_en;
    logic [1:0]            ist;
    logic [1:0]            ien;
    logic [11:0]           per_cnt;
    logic                  tick_d;
    lct_pkg::lct_state_t   st;
    logic [15:0]           cnt;
    logic [7:0]            prev_word;
    logic [31:0]           rdata;
    logic                  irq;
    logic                  rec_valid;
    logic [7:0]            rec_data;
    logic                  trig;
    logic                  done;
  } lct_top_st_t;

  lct_top_st_t r;
  lct_top_st_t next_r;
  logic        tick;
  logic        ext_rise;
  logic        ext_fall;
  logic [11:0] per_lim;
  logic [7:0]  vals;
  logic [7:0]  word_seq;
  logic        match;
  logic        unit;
  logic [1:0]  iset;
  logic [1:0]  iclr;
  logic        wr_ctrl;

  // ****************************************
  // Channel front ends and sequence
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < lct_pkg::NCH; gi++)
    begin : g_ch
      lct_chan u_chan (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .pin        (ch_pin[gi]),
        .tick       (tick),
        .latch_mode (r.inmode[gi]),
        .negative   (r.pol[gi]),
        .value      (vals[gi])
      );
      assign word_seq[gi] = r.seq_en[gi] & vals[r.seq_map[3*gi +: 3]];
    end
  endgenerate

  // ****************************************
  // Sample clock selection
  // ****************************************
  always_comb
  begin
    ext_rise = r.ext_s1 & ~r.ext_prev;
    ext_fall = ~r.ext_s1 & r.ext_prev;
    unique case (r.per_sel)
      lct_pkg::PER_SEL_FAST: per_lim = lct_pkg::PER_FAST_CYC;
      lct_pkg::PER_SEL_1US:  per_lim = lct_pkg::PER_1US_CYC;
      default:               per_lim = lct_pkg::PER_10US_CYC;
    endcase
    if (r.sync)
      tick = (ext_rise & r.edge_sel[0]) | (ext_fall & r.edge_sel[1]);
    else
      tick = (r.per_cnt >= per_lim - 12'h001);
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    next_r = r;
    iset = 2'h0;
    iclr = 2'h0;
    match = (vals == r.trig_word);
    unit = r.evt ? (word_seq != r.prev_word) : 1'b1;
    wr_ctrl = bus_we && bus_addr == lct_pkg::OFS_CTRL;
    next_r.ext_s0 = ext_clk_pin;
    next_r.ext_s1 = r.ext_s0;
    next_r.ext_prev = r.ext_s1;
    next_r.per_cnt = (r.sync || tick) ? 12'h000 : r.per_cnt + 12'h001;
    next_r.tick_d = tick;
    next_r.rec_valid = 1'b0;
    next_r.trig = 1'b0;

    // Bus writes
    if (bus_we)
    begin
      unique case (bus_addr)
        lct_pkg::OFS_CTRL:
        begin
          next_r.dig = bus_wdata[lct_pkg::CTRL_DIG];
          next_r.sync = bus_wdata[lct_pkg::CTRL_SYNC];
          next_r.edge_sel = bus_wdata[lct_pkg::CTRL_EDGE +: 2];
          next_r.per_sel = bus_wdata[lct_pkg::CTRL_PER +: 2];
          next_r.evt = bus_wdata[lct_pkg::CTRL_EVT];
        end
        lct_pkg::OFS_TRIG:    next_r.trig_word = bus_wdata[7:0];
        lct_pkg::OFS_DELAY:   next_r.delay = bus_wdata[15:0];
        lct_pkg::OFS_POL:     next_r.pol = bus_wdata[7:0];
        lct_pkg::OFS_INMODE:  next_r.inmode = bus_wdata[7:0];
        lct_pkg::OFS_SEQ_MAP: next_r.seq_map = bus_wdata[23:0];
        lct_pkg::OFS_SEQ_EN:  next_r.seq_en = bus_wdata[7:0];
        lct_pkg::OFS_ICLR:    iclr = bus_wdata[1:0];
        lct_pkg::OFS_IEN:     next_r.ien = bus_wdata[1:0];
        default:              next_r.ien = r.ien;
      endcase
    end

    // Acquisition sequence
    unique case (r.st)
      lct_pkg::LCT_IDLE, lct_pkg::LCT_DONE:
      begin
        if (wr_ctrl && bus_wdata[lct_pkg::CTRL_ARM])
        begin
          next_r.st = lct_pkg::LCT_ARMED;
          next_r.cnt = 16'h0000;
          next_r.done = 1'b0;
        end
      end
      lct_pkg::LCT_ARMED:
      begin
        if (r.tick_d)
        begin
          next_r.rec_valid = 1'b1;
          next_r.rec_data = word_seq;
          next_r.prev_word = word_seq;
          if (r.dig && match)
          begin
            next_r.trig = 1'b1;
            iset[lct_pkg::IRQ_TRIG] = 1'b1;
            next_r.cnt = 16'h0000;
            if (r.delay == 16'h0000)
            begin
              next_r.st = lct_pkg::LCT_DONE;
              next_r.done = 1'b1;
              iset[lct_pkg::IRQ_DONE] = 1'b1;
            end
            else
              next_r.st = lct_pkg::LCT_POST;
          end
        end
      end
      lct_pkg::LCT_POST:
      begin
        if (r.tick_d)
        begin
          next_r.rec_valid = 1'b1;
          next_r.rec_data = word_seq;
          next_r.prev_word = word_seq;
          if (unit)
          begin
            next_r.cnt = r.cnt + 16'h0001;
            if (r.cnt + 16'h0001 == r.delay)
            begin
              next_r.st = lct_pkg::LCT_DONE;
              next_r.done = 1'b1;
              iset[lct_pkg::IRQ_DONE] = 1'b1;
            end
          end
        end
      end
    endcase

    // Sticky interrupt status, set wins over clear
    next_r.ist = (r.ist & ~iclr) | iset;
    next_r.irq = |(next_r.ist & next_r.ien);

    // Bus reads
    next_r.rdata = 32'h0000_0000;
    if (bus_re)
    begin
      unique case (bus_addr)
        lct_pkg::OFS_CTRL:
          next_r.rdata = {24'h000000, r.evt, r.per_sel, r.edge_sel, r.sync, r.dig, 1'b0};
        lct_pkg::OFS_STATUS:  next_r.rdata = {14'h0000, r.cnt, r.st};
        lct_pkg::OFS_TRIG:    next_r.rdata = {24'h000000, r.trig_word};
        lct_pkg::OFS_DELAY:   next_r.rdata = {16'h0000, r.delay};
        lct_pkg::OFS_POL:     next_r.rdata = {24'h000000, r.pol};
        lct_pkg::OFS_INMODE:  next_r.rdata = {24'h000000, r.inmode};
        lct_pkg::OFS_SEQ_MAP: next_r.rdata = {8'h00, r.seq_map};
        lct_pkg::OFS_SEQ_EN:  next_r.rdata = {24'h000000, r.seq_en};
        lct_pkg::OFS_IST:     next_r.rdata = {30'h00000000, r.ist};
        lct_pkg::OFS_IEN:     next_r.rdata = {30'h00000000, r.ien};
        default:              next_r.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      r <= '0;
      r.dig <= lct_pkg::RST_CTRL[lct_pkg::CTRL_DIG];
      r.sync <= lct_pkg::RST_CTRL[lct_pkg::CTRL_SYNC];
      r.edge_sel <= lct_pkg::RST_CTRL[lct_pkg::CTRL_EDGE +: 2];
      r.per_sel <= lct_pkg::RST_CTRL[lct_pkg::CTRL_PER +: 2];
      r.evt <= lct_pkg::RST_CTRL[lct_pkg::CTRL_EVT];
      r.trig_word <= lct_pkg::RST_TRIG;
      r.delay <= lct_pkg::RST_DELAY;
      r.pol <= lct_pkg::RST_POL;
      r.inmode <= lct_pkg::RST_INMODE;
      r.seq_map <= lct_pkg::RST_SEQ_MAP;
      r.seq_en <= lct_pkg::RST_SEQ_EN;
      r.ien <= lct_pkg::RST_IEN;
      r.st <= lct_pkg::LCT_IDLE;
    end
    else
      r <= next_r;
  end

  assign bus_rdata = r.rdata;
  assign rec_valid = r.rec_valid;
  assign rec_data = r.rec_data;
  assign trig_pulse = r.trig;
  assign rec_done = r.done;
  assign irq = r.irq;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  arm_start_a: assert property (
    (r.st == lct_pkg::LCT_IDLE || r.st == lct_pkg::LCT_DONE) && wr_ctrl
      && bus_wdata[lct_pkg::CTRL_ARM] |=> r.st == lct_pkg::LCT_ARMED && !rec_done)
    else $error("arm did not start acquisition");
  analog_ignore_a: assert property (
    r.st == lct_pkg::LCT_ARMED && !r.dig |=> !trig_pulse && r.st == lct_pkg::LCT_ARMED)
    else $error("trigger fired with analog source");
  word_trig_a: assert property (
    r.st == lct_pkg::LCT_ARMED && r.tick_d && r.dig && vals == r.trig_word
      |=> trig_pulse && rec_valid && r.st != lct_pkg::LCT_ARMED)
    else $error("matching word did not trigger");
  delay_count_a: assert property (
    r.st == lct_pkg::LCT_POST && r.tick_d && unit && r.cnt + 16'h0001 != r.delay
      |=> r.cnt == $past(r.cnt) + 16'h0001 && r.st == lct_pkg::LCT_POST)
    else $error("delay unit not counted");
  delay_stop_a: assert property (
    r.st == lct_pkg::LCT_POST && r.tick_d && unit && r.cnt + 16'h0001 == r.delay
      |=> r.st == lct_pkg::LCT_DONE && rec_done && rec_valid)
    else $error("recording did not stop at delay");
  ext_edge_a: assert property (
    r.sync && ext_rise && r.edge_sel[0] && r.st == lct_pkg::LCT_ARMED
      && r.st == $past(r.st) |=> ##1 rec_valid)
    else $error("selected external edge not sampled");
  ext_only_a: assert property (
    r.sync && !ext_rise && !ext_fall |-> !tick)
    else $error("sampled without external edge");
  period_1us_a: assert property (
    tick && !r.sync && r.per_sel == lct_pkg::PER_SEL_1US
      |-> ##250 (tick || r.sync || r.per_sel != lct_pkg::PER_SEL_1US))
    else $error("internal 1 us period wrong");
  seq_ident_a: assert property (
    r.tick_d && r.seq_en == 8'hFF && r.seq_map == lct_pkg::RST_SEQ_MAP
      && r.st == lct_pkg::LCT_POST |=> rec_data == $past(vals))
    else $error("identity sequence altered data");

  trig_cov: cover property (trig_pulse);
  done_cov: cover property (r.st == lct_pkg::LCT_POST ##[1:1000] rec_done);
  both_cov: cover property (r.sync && r.edge_sel == 2'h3 && ext_fall && tick);
  events_cov: cover property (r.evt && r.st == lct_pkg::LCT_POST && r.tick_d && !unit);

endmodule

/* test/lct_target_model.sv */
module lct_target_model (
  // Control from the bench
  input  wire logic       run,
  input  wire logic       glitch,
  // Pins towards the capture block
  output logic      [7:0] ch_pin,
  output logic            ext_clk_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  parameter int HALF_NS = 40;

  logic [7:0] count;

  // ****************************************
  // Counting target with its own clock
  // ****************************************
  // Channel 0 can be flipped briefly to make a glitch between sample ticks
  assign ch_pin = count ^ {7'h00, glitch};

  initial
  begin
    count       = 8'h00;
    ext_clk_pin = 1'b0;
    forever
    begin
      if (run === 1'b1)
      begin
        ext_clk_pin = 1'b1;
        #(HALF_NS);
        ext_clk_pin = 1'b0;
        #(HALF_NS / 2);
        count = count + 8'h01;
        #(HALF_NS / 2);
      end
      else
        #1;
    end
  end
endmodule

/* test/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk, sys_rst, bus_we, bus_re, ext_clk_pin, rec_valid, trig_pulse;
  logic        rec_done, irq, run, glitch, seen_trig;
  logic [7:0]  bus_addr, ch_pin, rec_data, hold_val;
  logic [31:0] bus_wdata, bus_rdata, rdv;
  logic [23:0] rev_map;
  int          mismatches, total_checks, gap;
  logic [7:0]  ofs [12] = '{lct_pkg::OFS_CTRL, lct_pkg::OFS_STATUS, lct_pkg::OFS_TRIG,
                            lct_pkg::OFS_DELAY, lct_pkg::OFS_POL, lct_pkg::OFS_INMODE,
                            lct_pkg::OFS_SEQ_MAP, lct_pkg::OFS_SEQ_EN, lct_pkg::OFS_IST,
                            lct_pkg::OFS_ICLR, lct_pkg::OFS_IEN, 8'h3C};
  logic [31:0] rv  [12] = '{32'(lct_pkg::RST_CTRL), 32'h0, 32'(lct_pkg::RST_TRIG),
                            32'(lct_pkg::RST_DELAY), 32'(lct_pkg::RST_POL),
                            32'(lct_pkg::RST_INMODE), 32'(lct_pkg::RST_SEQ_MAP),
                            32'(lct_pkg::RST_SEQ_EN), 32'h0, 32'h0,
                            32'(lct_pkg::RST_IEN), 32'h0};
  logic [11:0] per [3]  = '{lct_pkg::PER_FAST_CYC, lct_pkg::PER_1US_CYC, lct_pkg::PER_10US_CYC};

  lct_top i_lct_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_we(bus_we), .bus_re(bus_re), .bus_rdata(bus_rdata),
    .ch_pin(ch_pin), .ext_clk_pin(ext_clk_pin), .rec_valid(rec_valid), .rec_data(rec_data),
    .trig_pulse(trig_pulse), .rec_done(rec_done), .irq(irq));

  lct_target_model i_lct_target_model (.run(run), .glitch(glitch), .ch_pin(ch_pin),
    .ext_clk_pin(ext_clk_pin));

  // ****************************************
  // Clock, checks and bus tasks
  // ****************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("Checks made: %0d, mismatches: %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_we    <= 1'b1;
    @(posedge sys_clk);
    bus_we    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_re   <= 1'b1;
    @(posedge sys_clk);
    bus_re   <= 1'b0;
    @(negedge sys_clk);
    d = bus_rdata;
  endtask

  // Waits for the next recorded sample, counting cycles and noting any trigger
  task automatic wait_valid(output int cyc, output logic trig_any);
    cyc      = 0;
    trig_any = 1'b0;
    do
    begin
      @(negedge sys_clk);
      cyc++;
      if (trig_pulse === 1'b1)
        trig_any = 1'b1;
    end while (rec_valid !== 1'b1 && cyc < 3000);
    check(32'(rec_valid), 32'h1);
  endtask

  // Arms one acquisition and follows it from trigger to the end of recording
  task automatic capture(input logic [7:0] ctrl, input logic [7:0] w, input logic [15:0] d,
                         input int n_exp, input logic [7:0] trig_exp, input logic [7:0] last_exp);
    int n;
    int k;
    wr(lct_pkg::OFS_TRIG, 32'(w));
    wr(lct_pkg::OFS_DELAY, 32'(d));
    wr(lct_pkg::OFS_CTRL, 32'(ctrl) | 32'h1);
    @(negedge sys_clk);
    check(32'(rec_done), 32'h0);
    k = 0;
    while (trig_pulse !== 1'b1 && k < 8000)
    begin
      @(negedge sys_clk);
      k++;
    end
    check(32'(trig_pulse), 32'h1);
    check(32'(rec_data), 32'(trig_exp));
    n = 0;
    while (rec_done !== 1'b1 && k < 16000)
    begin
      @(negedge sys_clk);
      k++;
      if (rec_valid === 1'b1)
        n++;
    end
    check(32'(rec_done), 32'h1);
    check(32'(rec_valid), 32'h1);
    if (n_exp >= 0)
      check(32'(n), 32'(n_exp));
    check(32'(rec_data), 32'(last_exp));
    rd(lct_pkg::OFS_STATUS, rdv);
    check(32'(rdv[1:0]), 32'h2);
  endtask

  // Reversed slots 0..3 only, as set up for the polarity test
  function automatic logic [7:0] seqw(input logic [7:0] c);
    return {4'h0, c[4], c[5], c[6], c[7]};
  endfunction

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    sys_rst      = 1'b1;
    bus_addr     = 8'h00;
    bus_wdata    = 32'h0;
    bus_we       = 1'b0;
    bus_re       = 1'b0;
    run          = 1'b1;
    glitch       = 1'b0;
    mismatches   = 0;
    total_checks = 0;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    wr(lct_pkg::OFS_STATUS, 32'hFFFFFFFF);
    wr(8'h3C, 32'hFFFFFFFF);
    for (int i = 0; i < 12; i++)
    begin
      rd(ofs[i], rdv);
      check(rdv, rv[i]);
    end
    capture(8'h0E, 8'h06, 16'h0005, 5, 8'h06, 8'h0B);
    capture(8'h16, 8'h40, 16'h0003, 3, 8'h40, 8'h43);
    capture(8'h1E, 8'h20, 16'h0004, 4, 8'h20, 8'h22);
    capture(8'h9E, 8'h80, 16'h0004, 8, 8'h80, 8'h84);
    capture(8'h0E, 8'h30, 16'h0000, 0, 8'h30, 8'h30);
    for (int k = 0; k < 8; k++)
      rev_map[3*k +: 3] = 3'(7 - k);
    wr(lct_pkg::OFS_POL, 32'hFF);
    wr(lct_pkg::OFS_SEQ_MAP, 32'(rev_map));
    wr(lct_pkg::OFS_SEQ_EN, 32'h0F);
    capture(8'h0E, 8'h35, 16'h0002, 2, seqw(8'h35), seqw(8'h33));
    wr(lct_pkg::OFS_POL, 32'h0);
    wr(lct_pkg::OFS_SEQ_MAP, 32'(lct_pkg::RST_SEQ_MAP));
    wr(lct_pkg::OFS_SEQ_EN, 32'(lct_pkg::RST_SEQ_EN));
    rd(lct_pkg::OFS_IST, rdv);
    check(rdv, 32'h3);
    check(32'(irq), 32'h0);
    wr(lct_pkg::OFS_IEN, 32'h2);
    repeat (2) @(negedge sys_clk);
    check(32'(irq), 32'h1);
    wr(lct_pkg::OFS_ICLR, 32'h2);
    rd(lct_pkg::OFS_IST, rdv);
    check(rdv, 32'h1);
    check(32'(irq), 32'h0);
    wr(lct_pkg::OFS_IEN, 32'h1);
    repeat (2) @(negedge sys_clk);
    check(32'(irq), 32'h1);
    wr(lct_pkg::OFS_ICLR, 32'h3);
    repeat (2) @(negedge sys_clk);
    check(32'(irq), 32'h0);
    // Target stopped: data constant, internal sample clock with analog source, then a digital trigger on the held word
    run <= 1'b0;
    repeat (40) @(posedge sys_clk);
    hold_val = ch_pin;
    wr(lct_pkg::OFS_TRIG, 32'(hold_val));
    wr(lct_pkg::OFS_DELAY, 32'h0);
    for (int p = 0; p < 3; p++)
    begin
      wr(lct_pkg::OFS_CTRL, (32'(p) << 5) | 32'h09);
      wait_valid(gap, seen_trig);
      wait_valid(gap, seen_trig);
      check(32'(gap), 32'(per[p]));
      check(32'(seen_trig), 32'h0);
      check(32'(rec_data), 32'(hold_val));
    end
    for (int m = 0; m < 2; m++)
    begin
      wr(lct_pkg::OFS_INMODE, 32'(1 - m));
      wait_valid(gap, seen_trig);
      repeat (100) @(posedge sys_clk);
      glitch <= 1'b1;
      repeat (10) @(posedge sys_clk);
      glitch <= 1'b0;
      wait_valid(gap, seen_trig);
      check(32'(rec_data[0]), (m == 0) ? {31'h0, ~hold_val[0]} : {31'h0, hold_val[0]});
    end
    wr(lct_pkg::OFS_CTRL, 32'h42);
    wait_valid(gap, seen_trig);
    check(32'(seen_trig), 32'h1);
    check(32'(rec_done), 32'h1);
    tally_and_finish();
  end

  // ****************************************
  // Watchdog
  // ****************************************
  initial
  begin
    #400000;
    mismatches++;
    tally_and_finish();
  end
endmodule
